// file: verilog/sbra_defines.svh
// Purpose: Constants for the system bus round-robin arbiter
// Assumes: Included by the package and the arbiter module
// Notes: Master index order is also the fixed base priority order
`ifndef SBRA_DEFINES_SVH
`define SBRA_DEFINES_SVH

// ********************************************************
// Master indices (base priority, 0 highest)
// ********************************************************
`define SBRA_NUM_MASTERS 10
`define SBRA_IDX_CPU 0
`define SBRA_IDX_TEST 1
`define SBRA_IDX_DMA_BASE 2
`define SBRA_NUM_DMA 4

// ********************************************************
// Reset values
// ********************************************************
`define SBRA_PTR_RESET 4'h0
`define SBRA_GRANT_RESET 10'h000

`endif

// file: verilog/sbra_pkg.sv
// Purpose: Types for the system bus round-robin arbiter
// Assumes: sbra_defines.svh is on the include path
// Notes: Request carrier groups per-master request attributes
`include "sbra_defines.svh"

package sbra_pkg;

   // Per-master request: valid, direction, addressed
   typedef struct packed {
      logic valid;
      logic is_write;
      logic addressed;
   } sbra_req_t;

   // Grant outcome for one bus cycle
   typedef struct packed {
      logic [`SBRA_NUM_MASTERS-1:0] grant;
      logic uses_addr;
      logic uses_rd;
      logic uses_wr;
   } sbra_gnt_t;

endpackage

// file: verilog/sbra_arbiter.sv
// Purpose: Round-robin arbiter for the on-chip system bus
// Assumes: Masters hold requests until granted; one grant per master per cycle
// Notes: Up to two transfers are issued per cycle when they do not conflict
`timescale 1ns/1ps
`default_nettype none
`include "sbra_defines.svh"

// Overview of operation
// - Accept requests from ten masters: processor, test port, DMA read and write.
// - Grant in round-robin order built on a fixed base priority order.
// - Rotate priority after each grant among currently requesting masters only.
// - Up to two transactions may be issued in one bus cycle.
// - A pair holds at most one addressed transfer.
// - A pair holds exactly one read and one write.
// - Processor read uses address and read-data buses.
// - Processor write uses address and write-data buses.
// - DMA acknowledge read uses only the read-data bus.
// - DMA acknowledge write uses only the write-data bus.
// - DMA addressed read uses address and read-data buses.
// - DMA addressed write uses address and write-data buses.
module sbra_arbiter
   import sbra_pkg::*;
#(
   parameter int NUM_DMA = `SBRA_NUM_DMA
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic test_req,
   input wire logic test_write,
   input wire logic [NUM_DMA-1:0] dma_rd_req,
   input wire logic [NUM_DMA-1:0] dma_rd_addressed,
   input wire logic [NUM_DMA-1:0] dma_wr_req,
   input wire logic [NUM_DMA-1:0] dma_wr_addressed,
   output logic [2*NUM_DMA+1:0] grant,
   output logic addr_bus_busy,
   output logic rd_bus_busy,
   output logic wr_bus_busy
);

   localparam int NM = 2 * NUM_DMA + 2;
   localparam int PW = $clog2(NM);

   // ********************************************************
   // Elaboration checks
   // ********************************************************
   // Refuse channel counts that do not give the ten requesters of the base order
   generate
      if (NUM_DMA < 1 || NM != `SBRA_NUM_MASTERS) begin : g_bad_dma
         $error("sbra_arbiter: NUM_DMA must give ten masters");
      end
   endgenerate

   // ********************************************************
   // Request classification
   // ********************************************************
   sbra_req_t req [NM];
   logic [PW-1:0] ptr;
   logic [NM-1:0] next_grant;
   logic next_addr;
   logic next_rd;
   logic next_wr;
   logic [PW-1:0] next_ptr;

   // Processor and test port are always addressed transfers
   assign req[`SBRA_IDX_CPU] = '{valid: cpu_req, is_write: cpu_write,
                                addressed: 1'b1};
   assign req[`SBRA_IDX_TEST] = '{valid: test_req, is_write: test_write,
                                 addressed: 1'b1};

   // DMA read and write halves are separate requesters
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DMA; gi++) begin : g_dma
         assign req[`SBRA_IDX_DMA_BASE + 2*gi] = '{valid: dma_rd_req[gi], is_write: 1'b0,
            addressed: dma_rd_addressed[gi]};
         assign req[`SBRA_IDX_DMA_BASE + 2*gi + 1] = '{valid: dma_wr_req[gi],
            is_write: 1'b1, addressed: dma_wr_addressed[gi]};
      end
   endgenerate

   // ********************************************************
   // Round-robin selection with pairing
   // ********************************************************
   // Scan from the pointer in base order; first is primary, second must fit
   always_comb begin
      int idx;
      int cnt;
      logic busy_a;
      logic busy_r;
      logic busy_w;
      logic use_a;
      logic first_found;
      int first_idx;
      idx = 0;
      cnt = 0;
      busy_a = 1'b0;
      busy_r = 1'b0;
      busy_w = 1'b0;
      use_a = 1'b0;
      first_found = 1'b0;
      first_idx = 0;
      next_grant = '0;
      for (int k = 0; k < NM; k++) begin
         idx = (int'(ptr) + k) % NM;
         use_a = req[idx].addressed;
         if (req[idx].valid && cnt < 2) begin
            // Conflict on any shared bus leaves the request pending
            if (!(use_a && busy_a) && !(req[idx].is_write ? busy_w : busy_r)) begin
               next_grant[idx] = 1'b1;
               cnt = cnt + 1;
               busy_a = busy_a | use_a;
               busy_w = busy_w | req[idx].is_write;
               busy_r = busy_r | ~req[idx].is_write;
               if (!first_found) begin
                  first_found = 1'b1;
                  first_idx = idx;
               end
            end
         end
      end
      next_addr = busy_a;
      next_rd = busy_r;
      next_wr = busy_w;
      // Rotate past the primary winner only while someone is requesting
      if (first_found) begin
         next_ptr = PW'((first_idx + 1) % NM);
      end else begin
         next_ptr = ptr;
      end
   end

   // ********************************************************
   // Registered state and outputs
   // ********************************************************
   // Priority pointer
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ptr <= PW'(`SBRA_PTR_RESET);
      end else begin
         ptr <= next_ptr;
      end
   end

   // Grant and bus-usage outputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         grant <= `SBRA_GRANT_RESET;
         addr_bus_busy <= 1'b0;
         rd_bus_busy <= 1'b0;
         wr_bus_busy <= 1'b0;
      end else begin
         grant <= next_grant;
         addr_bus_busy <= next_addr;
         rd_bus_busy <= next_rd;
         wr_bus_busy <= next_wr;
      end
   end

endmodule
`default_nettype wire

// file: sim/sbra_arbiter_assertions.sv
// Purpose: Port checker for the arbiter
// Assumes: Grants lag requests by one cycle
// Notes: Bound to every arbiter instance
`timescale 1ns/1ps
`default_nettype none
module sbra_arbiter_assertions #(parameter int NUM_DMA = 4)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic [NUM_DMA-1:0] dma_rd_addressed,
   input wire logic [2*NUM_DMA+1:0] grant,
   input wire logic addr_bus_busy,
   input wire logic rd_bus_busy,
   input wire logic wr_bus_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Pairing limits and bus use per transfer kind
   a_two_max: assert property ($countones(grant) < 3) else $error("many");
   a_pair_rw: assert property (
      $countones(grant) == 2 |-> rd_bus_busy && wr_bus_busy) else $error("pair dir");
   a_pair_addr: assert property (
      grant[0] && grant[2] |-> !$past(dma_rd_addressed[0])) else $error("pair addr");
   a_cpu_read: assert property (
      grant[0] && !$past(cpu_write) |-> addr_bus_busy && rd_bus_busy) else $error("cpu rd");
   a_cpu_write: assert property (
      grant[0] && $past(cpu_write) |-> addr_bus_busy && wr_bus_busy) else $error("cpu wr");
   a_ack_read: assert property (
      grant == 10'h004 && !$past(dma_rd_addressed[0])
      |-> {addr_bus_busy, rd_bus_busy, wr_bus_busy} == 3'h2) else $error("ack");
   a_cpu_cause: assert property (grant[0] |-> $past(cpu_req)) else $error("cause");
   a_no_idle: assert property (
      $past(arst_n) && $past(cpu_req) |-> grant != 10'h000) else $error("idle");
   c_pair: cover property (grant == 10'h005);
   c_held: cover property ($past(cpu_req) && !grant[0]);
   c_rot: cover property (grant[1] ##1 grant[2]);
endmodule
bind sbra_arbiter sbra_arbiter_assertions #(.NUM_DMA(NUM_DMA)) u_chk (.clock(clock),
   .arst_n(arst_n), .cpu_req(cpu_req), .cpu_write(cpu_write),
   .dma_rd_addressed(dma_rd_addressed), .grant(grant), .addr_bus_busy(addr_bus_busy),
   .rd_bus_busy(rd_bus_busy), .wr_bus_busy(wr_bus_busy));
`default_nettype wire

// file: sim/sbra_masters_model.sv
// Purpose: Bus masters holding requests until granted
// Assumes: Bit order of the arbiter grant
// Notes: Posts add pending requests
`timescale 1ns/1ps
`default_nettype none
module sbra_masters_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [9:0] post,
   input wire logic [9:0] grant,
   output logic [9:0] req
);
   logic [9:0] pend;
   // Pending set grows by posts, shrinks by grants
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) pend <= 10'h000;
      else pend <= (pend | post) & ~grant;
   end
   // Granted master drops at once; DMA halves ask apart
   assign req = pend & ~grant;
endmodule
`default_nettype wire

// file: sim/test_sbra_arbiter.sv
// Purpose: Bench for the arbiter
// Assumes: Grant one cycle after request
// Notes: Pointer carries over between tests
`timescale 1ns/1ps
`default_nettype none
module test_sbra_arbiter;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic cw = 1'b0;
   logic [3:0] ra = 4'h0, wa = 4'h0;
   logic [9:0] post = 10'h000, req, grant;
   logic ab, rb, wb;
   int bad_count = 0, n_tests = 0, cycles = 0;
   always #10 clock = ~clock;
   sbra_masters_model u_mst (.clock(clock), .arst_n(arst_n), .post(post), .grant(grant),
      .req(req));
   sbra_arbiter u_dut (.clock(clock), .arst_n(arst_n), .cpu_req(req[0]), .cpu_write(cw),
      .test_req(req[1]), .test_write(cw), .dma_rd_req({req[8], req[6], req[4], req[2]}),
      .dma_rd_addressed(ra), .dma_wr_req({req[9], req[7], req[5], req[3]}),
      .dma_wr_addressed(wa), .grant(grant), .addr_bus_busy(ab), .rd_bus_busy(rb),
      .wr_bus_busy(wb));
   task automatic chk_g(input logic [9:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic [2:0] got, exp);
      chk_g({7'h00, got}, {7'h00, exp});
   endtask
   // Post requests with their kinds
   task automatic start(input logic [9:0] s, input logic w, input logic [3:0] r, x);
      @(posedge clock);
      cw <= w;
      ra <= r;
      wa <= x;
      post <= s;
      @(posedge clock);
      post <= 10'h000;
   endtask
   task automatic step(input logic [9:0] exp);
      @(posedge clock);
      #1 chk_g(grant, exp);
   endtask
   task automatic t_pair;
      start(10'h005, 1'b1, 4'h0, 4'h0);
      step(10'h005);
      chk_b({ab, rb, wb}, 3'h7);
      step(10'h000);
      $display("test pair done");
   endtask
   task automatic t_clash;
      start(10'h009, 1'b1, 4'h0, 4'h1);
      step(10'h008);
      chk_b({ab, rb, wb}, 3'h5);
      step(10'h001);
      $display("test clash done");
   endtask
   task automatic t_rotate;
      start(10'h3FF, 1'b0, 4'hF, 4'hF);
      for (int i = 1; i < 11; i++) step(10'h001 << (i % 10));
      $display("test rotate done");
   endtask
   // Test-port write pairs with an acknowledge read; acknowledge write waits
   task automatic t_ackw;
      start(10'h032, 1'b1, 4'h0, 4'h0);
      step(10'h012);
      chk_b({ab, rb, wb}, 3'h7);
      step(10'h020);
      chk_b({ab, rb, wb}, 3'h1);
      $display("test ackw done");
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         conclude;
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      t_pair;
      t_clash;
      t_rotate;
      t_ackw;
      conclude;
   end
endmodule
`default_nettype wire
